// file: rtl/ted_axis_level.sv
module ted_axis_level
    import ted_pkg::*;
#(
    parameter int ACC_W = 16
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Samples, signed, in mg
    input  wire logic             smp_valid,
    input  wire logic [ACC_W-1:0] acc_x,
    input  wire logic [ACC_W-1:0] acc_y,
    input  wire logic [ACC_W-1:0] acc_z,
    // Setup
    input  wire logic [1:0]       axis,
    input  wire logic [7:0]       level,
    input  wire logic [1:0]       meas_range,
    // Result
    output logic                  hit_valid,
    output logic                  above
);

    logic [ACC_W-1:0] sel;
    logic [ACC_W:0]   mag;
    logic [7:0]       cap;
    logic [7:0]       impact_level_limit;
    logic [17:0]      lim_mg;

    always_comb begin
        sel = acc_x;
        if (axis == AXIS_Y) begin
            sel = acc_y;
        end else if (axis == AXIS_Z) begin
            sel = acc_z;
        end
        // Unsigned magnitude; one extra bit keeps the most negative code
        if (sel[ACC_W-1]) begin
            mag = (ACC_W+1)'(0) - {1'b1, sel};
        end else begin
            mag = {1'b0, sel};
        end
        case (meas_range)
            2'h0:    cap = CAP_RANGE0;
            2'h1:    cap = CAP_RANGE1;
            default: cap = CAP_RANGE2;
        endcase
        impact_level_limit = (level > cap) ? cap : level;
        lim_mg = 18'(impact_level_limit) * 18'(LEVEL_MG);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hit_valid <= 1'b0;
            above     <= 1'b0;
        end else begin
            hit_valid <= smp_valid && (axis != AXIS_NONE);
            above     <= (18'(mag) > lim_mg) && (level != 8'h00);
        end
    end

endmodule

// file: rtl/ted_pkg.sv
package ted_pkg;

    // ----------------------------------------------------------------
    // Register map (word index, byte address is four times the index)
    // ----------------------------------------------------------------
    localparam int          ADDR_W       = 12;
    localparam int          IDX_W        = 10;
    localparam logic [9:0]  IDX_LEVEL    = 10'h043;
    localparam logic [9:0]  IDX_WIDTH    = 10'h044;
    localparam logic [9:0]  IDX_WAIT     = 10'h045;
    localparam logic [9:0]  IDX_WINDOW   = 10'h046;
    localparam logic [9:0]  IDX_SETUP    = 10'h047;
    localparam logic [9:0]  IDX_STATUS   = 10'h060;
    localparam logic [9:0]  IDX_MASK     = 10'h061;
    localparam logic [9:0]  IDX_STATE    = 10'h062;

    localparam logic [7:0]  REG_RST      = 8'h00;
    localparam logic [7:0]  SETUP_MASK   = 8'h07;
    localparam int          SETUP_TRIPLE = 2;
    localparam int          SETUP_AXIS   = 0;

    // ----------------------------------------------------------------
    // Axis codes and events
    // ----------------------------------------------------------------
    localparam logic [1:0]  AXIS_X       = 2'h0;
    localparam logic [1:0]  AXIS_Y       = 2'h1;
    localparam logic [1:0]  AXIS_Z       = 2'h2;
    localparam logic [1:0]  AXIS_NONE    = 2'h3;
    localparam int          EVT_W        = 3;
    localparam int          EVT_SINGLE   = 0;
    localparam int          EVT_DOUBLE   = 1;
    localparam int          EVT_TRIPLE   = 2;

    // ----------------------------------------------------------------
    // Threshold scale; cap is twice the range in g, in 500 mg steps
    // ----------------------------------------------------------------
    localparam int          LEVEL_MG     = 500;
    localparam logic [7:0]  CAP_RANGE0   = 8'h10;
    localparam logic [7:0]  CAP_RANGE1   = 8'h20;
    localparam logic [7:0]  CAP_RANGE2   = 8'h40;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int          CLK_NS       = 8;
    localparam int          WIDTH_STEP_NS  = 625000;
    localparam int          REPEAT_STEP_NS = 1250000;
    localparam int          WIDTH_STEP_CYC = WIDTH_STEP_NS / CLK_NS;
    localparam int          REPEAT_STEP_CYC = REPEAT_STEP_NS / CLK_NS;

    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b000,
        ST_PULSE   = 3'b001,
        ST_LATENCY = 3'b010,
        ST_WINDOW  = 3'b011,
        ST_REJECT  = 3'b100
    } ted_state_e;

endpackage

// file: rtl/ted_tap_detect.sv
// Added by the designer: register access over AXI4-Lite.
module ted_tap_detect
    import ted_pkg::*;
#(
    parameter int          ACC_W           = 16,
    parameter int unsigned WIDTH_STEP_CYC  = ted_pkg::WIDTH_STEP_CYC,
    parameter int unsigned REPEAT_STEP_CYC = ted_pkg::REPEAT_STEP_CYC
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Acceleration samples, signed mg
    input  wire logic              smp_valid,
    input  wire logic [ACC_W-1:0]  acc_x,
    input  wire logic [ACC_W-1:0]  acc_y,
    input  wire logic [ACC_W-1:0]  acc_z,
    input  wire logic [1:0]        meas_range,
    // Events
    output logic [EVT_W-1:0]       tap_event,
    output logic                   irq
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0]        impact_level_reg;
    logic [7:0]        impact_max_width_reg;
    logic [7:0]        repeat_wait_reg;
    logic [7:0]        repeat_window_reg;
    logic [7:0]        impact_setup_reg;
    logic [EVT_W-1:0]  evt_status;
    logic [EVT_W-1:0]  evt_mask;

    logic              aw_held;
    logic              w_held;
    logic [IDX_W-1:0]  aw_idx;
    logic [31:0]       w_data;
    logic              w_lane0;
    logic              wr_do;
    logic              wr_hit;
    logic              wr_en;
    logic [IDX_W-1:0]  ar_idx;
    logic [31:0]       rd_val;
    logic              rd_hit;

    ted_state_e        state;
    logic [1:0]        taps;
    logic [8:0]        phase_cnt;
    logic              hit_valid;
    logic              above;
    logic              tick_width;
    logic              tick_repeat;
    logic              clr_width;
    logic              clr_repeat;
    logic              cfg_ok;
    logic              triple_en;
    logic [1:0]        axis;
    logic              tap_done;
    logic [1:0]        next_taps;
    logic [EVT_W-1:0]  next_event;
    logic [EVT_W-1:0]  status_clr;

    assign triple_en = impact_setup_reg[SETUP_TRIPLE];
    assign axis      = impact_setup_reg[SETUP_AXIS +: 2];

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    // Address and data are held apart, so either may come first
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign wr_do         = aw_held && w_held;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_idx  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_idx  <= s_axi_awaddr[ADDR_W-1:2];
        end else if (wr_do) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            w_data  <= '0;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_lane0 <= s_axi_wstrb[0];
        end else if (wr_do) begin
            w_held <= 1'b0;
        end
    end

    always_comb begin
        if (aw_idx == IDX_LEVEL || aw_idx == IDX_WIDTH) begin
            wr_hit = 1'b1;
        end else if (aw_idx == IDX_WAIT || aw_idx == IDX_WINDOW) begin
            wr_hit = 1'b1;
        end else if (aw_idx == IDX_SETUP || aw_idx == IDX_STATUS) begin
            wr_hit = 1'b1;
        end else if (aw_idx == IDX_MASK || aw_idx == IDX_STATE) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Only byte lane 0 carries register bits
    assign wr_en = wr_do && w_lane0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            impact_level_reg     <= REG_RST;
            impact_max_width_reg <= REG_RST;
            repeat_wait_reg      <= REG_RST;
            repeat_window_reg    <= REG_RST;
            impact_setup_reg     <= REG_RST;
        end else if (wr_en) begin
            if (aw_idx == IDX_LEVEL) begin
                impact_level_reg <= w_data[7:0];
            end else if (aw_idx == IDX_WIDTH) begin
                impact_max_width_reg <= w_data[7:0];
            end else if (aw_idx == IDX_WAIT) begin
                repeat_wait_reg <= w_data[7:0];
            end else if (aw_idx == IDX_WINDOW) begin
                repeat_window_reg <= w_data[7:0];
            end else if (aw_idx == IDX_SETUP) begin
                // Reserved bits stay zero
                impact_setup_reg <= w_data[7:0] & SETUP_MASK;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_mask <= '0;
        end else if (wr_en && aw_idx == IDX_MASK) begin
            evt_mask <= w_data[EVT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;
    assign ar_idx        = s_axi_araddr[ADDR_W-1:2];

    always_comb begin
        rd_hit = 1'b1;
        rd_val = '0;
        if (ar_idx == IDX_LEVEL) begin
            rd_val[7:0] = impact_level_reg;
        end else if (ar_idx == IDX_WIDTH) begin
            rd_val[7:0] = impact_max_width_reg;
        end else if (ar_idx == IDX_WAIT) begin
            rd_val[7:0] = repeat_wait_reg;
        end else if (ar_idx == IDX_WINDOW) begin
            rd_val[7:0] = repeat_window_reg;
        end else if (ar_idx == IDX_SETUP) begin
            rd_val[7:0] = impact_setup_reg;
        end else if (ar_idx == IDX_STATUS) begin
            rd_val[EVT_W-1:0] = evt_status;
        end else if (ar_idx == IDX_MASK) begin
            rd_val[EVT_W-1:0] = evt_mask;
        end else if (ar_idx == IDX_STATE) begin
            rd_val[4:0] = {taps, state};
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Magnitude and time bases
    // ----------------------------------------------------------------
    ted_axis_level #(
        .ACC_W      (ACC_W)
    ) u_level (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .smp_valid  (smp_valid),
        .acc_x      (acc_x),
        .acc_y      (acc_y),
        .acc_z      (acc_z),
        .axis       (axis),
        .level      (impact_level_reg),
        .meas_range (meas_range),
        .hit_valid  (hit_valid),
        .above      (above)
    );

    // Dividers restart at each phase so no step is cut short
    assign clr_width  = (state != ST_PULSE);
    assign clr_repeat = (state != ST_LATENCY && state != ST_WINDOW)
                        || (state == ST_LATENCY && tick_repeat
                            && phase_cnt == 9'(repeat_wait_reg) - 9'h001);

    ted_tick_div #(
        .PERIOD  (WIDTH_STEP_CYC)
    ) u_width_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (clr_width),
        .tick    (tick_width)
    );

    ted_tick_div #(
        .PERIOD  (REPEAT_STEP_CYC)
    ) u_repeat_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clr     (clr_repeat),
        .tick    (tick_repeat)
    );

    // ----------------------------------------------------------------
    // Tap sequencer
    // ----------------------------------------------------------------
    assign cfg_ok    = (impact_level_reg != 8'h00)
                       && (axis != AXIS_NONE);
    assign tap_done  = hit_valid && !above;
    assign next_taps = taps + 2'h1;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state     <= ST_IDLE;
            taps      <= 2'h0;
            phase_cnt <= '0;
        end else if (!cfg_ok) begin
            state     <= ST_IDLE;
            taps      <= 2'h0;
            phase_cnt <= '0;
        end else begin
            case (state)
                ST_IDLE: begin
                    taps      <= 2'h0;
                    phase_cnt <= '0;
                    if (hit_valid && above) begin
                        state <= ST_PULSE;
                    end
                end
                ST_PULSE: begin
                    if (tick_width
                        && phase_cnt == 9'(impact_max_width_reg)) begin
                        state <= ST_REJECT;
                    end else if (tap_done) begin
                        phase_cnt <= '0;
                        if (repeat_wait_reg == 8'h00) begin
                            state <= ST_IDLE;
                        end else if (taps == 2'h0
                                     || (taps == 2'h1 && triple_en)) begin
                            taps  <= next_taps;
                            state <= ST_LATENCY;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end else if (tick_width) begin
                        phase_cnt <= phase_cnt + 9'h001;
                    end
                end
                ST_REJECT: begin
                    // Too long a pulse ends the sequence once it falls
                    if (tap_done) begin
                        state <= ST_IDLE;
                    end
                end
                ST_LATENCY: begin
                    // Samples in this phase are ignored on purpose
                    if (tick_repeat) begin
                        if (phase_cnt == 9'(repeat_wait_reg) - 9'h001) begin
                            phase_cnt <= '0;
                            state     <= (repeat_window_reg == 8'h00)
                                         ? ST_IDLE : ST_WINDOW;
                        end else begin
                            phase_cnt <= phase_cnt + 9'h001;
                        end
                    end
                end
                ST_WINDOW: begin
                    if (hit_valid && above) begin
                        phase_cnt <= '0;
                        state     <= ST_PULSE;
                    end else if (tick_repeat) begin
                        if (phase_cnt == 9'(repeat_window_reg)
                                         - 9'h001) begin
                            state <= ST_IDLE;
                        end else begin
                            phase_cnt <= phase_cnt + 9'h001;
                        end
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Events
    // ----------------------------------------------------------------
    always_comb begin
        next_event = '0;
        if (cfg_ok && state == ST_PULSE && tap_done
            && !(tick_width && phase_cnt == 9'(impact_max_width_reg))) begin
            if (taps == 2'h0) begin
                next_event[EVT_SINGLE] = 1'b1;
            end else if (taps == 2'h1) begin
                next_event[EVT_DOUBLE] = 1'b1;
            end else begin
                next_event[EVT_TRIPLE] = triple_en;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tap_event <= '0;
        end else begin
            tap_event <= next_event;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------
    assign status_clr = (wr_en && aw_idx == IDX_STATUS)
                        ? w_data[EVT_W-1:0] : '0;

    // A new event wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_status <= '0;
        end else begin
            evt_status <= (evt_status & ~status_clr) | tap_event;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_status & evt_mask);
        end
    end

endmodule

// file: rtl/ted_tick_div.sv
module ted_tick_div
    import ted_pkg::*;
#(
    parameter int unsigned PERIOD = 8
) (
    // Clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // Control
    input  wire logic clr,
    output logic      tick
);

    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt;

    // Restart on clear so a phase always spans whole steps
    always_ff @(posedge aclk) begin
        if (!aresetn || clr) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt == LAST) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + CW'(1);
            tick <= 1'b0;
        end
    end

endmodule

// file: test/ted_tap_detect_chk.sv
module ted_tap_detect_chk (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // Samples and events
    input wire logic        smp_valid,
    input wire logic [2:0]  tap_event,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_rd_req;
        s_axi_arvalid && s_axi_arready;
    endsequence
    evt_onehot_a: assert property ($onehot0(tap_event))
        else $error("two tap events at once");
    evt_pulse_a: assert property (tap_event != 3'h0 |=> tap_event == 3'h0)
        else $error("tap event longer than one cycle");
    evt_cause_a: assert property (tap_event != 3'h0 |-> $past(smp_valid, 2))
        else $error("tap event without its sample");
    rst_quiet_a: assert property (disable iff (1'b0)
        !aresetn |=> tap_event == 3'h0 && !irq && !s_axi_bvalid)
        else $error("outputs active after reset");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    rd_answer_a: assert property (s_rd_req |=> s_axi_rvalid)
        else $error("read not answered");
    wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready
        && !s_axi_wready)
        else $error("write taken while response pending");
endmodule

bind ted_tap_detect ted_tap_detect_chk ted_tap_detect_chk_inst (.*);

// file: test/ted_tap_detect_tb.sv
module ted_tap_detect_tb import ted_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk, aresetn, smp_valid, irq, s_axi_awvalid;
    logic        s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready;
    logic [1:0]  s_axi_bresp, s_axi_rresp, meas_range;
    logic [3:0]  s_axi_wstrb;
    logic [2:0]  tap_event;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [15:0] acc_x, acc_y, acc_z;
    int          miscompares, checks;

    // Short steps keep the timed windows to a few dozen cycles
    ted_tap_detect #(.WIDTH_STEP_CYC(4), .REPEAT_STEP_CYC(8))
        ted_tap_detect_inst (.*);

    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    // --------
    // Helpers
    // --------
    task ck(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    task idle(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Ready is sampled mid-cycle, so the release lands on the taking edge
    task wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] r);
        logic       a, w, b, t;
        logic [1:0] rs;
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        t = 1'h0;
        while (!t) begin
            @(negedge aclk);
            a = s_axi_awvalid & s_axi_awready;
            w = s_axi_wvalid & s_axi_wready;
            {b, rs} = {s_axi_bvalid, s_axi_bresp};
            t = b & s_axi_bready;
            @(posedge aclk);
            if (a) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            // Late ready makes the slave hold its answer a cycle
            if (b && !t) s_axi_bready <= 1'h1;
        end
        s_axi_bready <= 1'h0;
        ck("bresp", {30'h0, r}, {30'h0, rs});
    endtask
    task rd(input logic [9:0] i, input logic [7:0] d, input logic [1:0] r);
        logic        a, b, t;
        logic [31:0] dt;
        logic [1:0]  rs;
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        t = 1'h0;
        while (!t) begin
            @(negedge aclk);
            a = s_axi_arvalid & s_axi_arready;
            {b, dt, rs} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            t = b & s_axi_rready;
            @(posedge aclk);
            if (a) s_axi_arvalid <= 1'h0;
            if (b && !t) s_axi_rready <= 1'h1;
        end
        s_axi_rready <= 1'h0;
        ck("rdata", {24'h0, d}, dt);
        ck("rresp", {30'h0, r}, {30'h0, rs});
    endtask
    // Axis code 3 drives all three axes at once
    task tap(input logic [1:0] a, input logic [15:0] m, input int n,
             input logic [2:0] e);
        logic [2:0]  seen;
        logic [15:0] v;
        seen = 3'h0;
        for (int k = 0; k < n + 8; k++) begin
            v = (k < n) ? m : 16'h0;
            acc_x <= (a == 2'h1 || a == 2'h2) ? 16'h0 : v;
            acc_y <= a[0] ? v : 16'h0;
            acc_z <= a[1] ? v : 16'h0;
            @(negedge aclk);
            seen = seen | tap_event;
            @(posedge aclk);
        end
        ck("tap_event", {29'h0, e}, {29'h0, seen});
    endtask
    // --------
    // Scenarios
    // --------
    task t_regs;
        for (int k = 0; k < 5; k++)
            rd(IDX_LEVEL + 10'(k), REG_RST, RESP_OKAY);
        rd(IDX_STATUS, REG_RST, RESP_OKAY);
        rd(IDX_MASK, REG_RST, RESP_OKAY);
        wr(IDX_SETUP, 8'hFF, RESP_OKAY);
        rd(IDX_SETUP, SETUP_MASK, RESP_OKAY);
        wr(10'h050, 8'h5A, RESP_SLVERR);
        rd(10'h050, 8'h00, RESP_SLVERR);
        wr(IDX_LEVEL, 8'h02, RESP_OKAY);
        rd(IDX_LEVEL, 8'h02, RESP_OKAY);
        wr(IDX_WIDTH, 8'h02, RESP_OKAY);
        wr(IDX_WINDOW, 8'h04, RESP_OKAY);
    endtask
    task t_axis;
        for (int k = 0; k < 4; k++) begin
            wr(IDX_SETUP, 8'(k), RESP_OKAY);
            tap(2'(k), 16'hFB50, 2, (k < 3) ? 3'h1 : 3'h0);
        end
    endtask
    task t_level;
        wr(IDX_SETUP, 8'h00, RESP_OKAY);
        tap(2'h0, 16'h03E8, 2, 3'h0);
        tap(2'h0, 16'h03E9, 2, 3'h1);
        wr(IDX_LEVEL, 8'h30, RESP_OKAY);
        tap(2'h0, 16'h2328, 2, 3'h1);
        meas_range <= 2'h1;
        tap(2'h0, 16'h3E81, 2, 3'h1);
        meas_range <= 2'h2;
        tap(2'h0, 16'h2328, 2, 3'h0);
        wr(IDX_LEVEL, 8'h00, RESP_OKAY);
        tap(2'h0, 16'h2328, 2, 3'h0);
        wr(IDX_LEVEL, 8'h02, RESP_OKAY);
        tap(2'h0, 16'h2328, 20, 3'h0);
        tap(2'h0, 16'h2328, 2, 3'h1);
    endtask
    task t_repeat;
        tap(2'h0, 16'h2328, 2, 3'h1);
        idle(15);
        tap(2'h0, 16'h2328, 2, 3'h1);
        wr(IDX_WAIT, 8'h04, RESP_OKAY);
        tap(2'h0, 16'h2328, 2, 3'h1);
        tap(2'h0, 16'h2328, 2, 3'h0);
        idle(90);
        tap(2'h0, 16'h2328, 2, 3'h1);
        wr(IDX_WAIT, 8'h02, RESP_OKAY);
        idle(90);
        for (int k = 0; k < 2; k++) begin
            wr(IDX_SETUP, {5'h0, ~k[0], 2'h0}, RESP_OKAY);
            tap(2'h0, 16'h2328, 2, 3'h1);
            idle(15);
            tap(2'h0, 16'h2328, 2, 3'h2);
            idle(15);
            tap(2'h0, 16'h2328, 2, k ? 3'h1 : 3'h4);
            idle(90);
        end
    endtask
    task t_irq;
        rd(IDX_STATUS, 8'h07, RESP_OKAY);
        ck("irq", 32'h0, {31'h0, irq});
        wr(IDX_MASK, 8'h04, RESP_OKAY);
        idle(2);
        ck("irq", 32'h1, {31'h0, irq});
        wr(IDX_STATUS, 8'h04, RESP_OKAY);
        idle(2);
        ck("irq", 32'h0, {31'h0, irq});
        rd(IDX_STATUS, 8'h03, RESP_OKAY);
    endtask
    task complete_run;
        if (miscompares == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, meas_range} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        {acc_x, acc_y, acc_z} = 48'h0;
        {s_axi_wstrb, smp_valid} = 5'h1F;
        {miscompares, checks} = 64'h0;
        idle(5);
        aresetn <= 1'h1;
        t_regs;
        t_axis;
        t_level;
        t_repeat;
        t_irq;
        complete_run;
    end
    initial begin
        #100000;
        miscompares++;
        complete_run;
    end
endmodule
